/* File: design/cls_pkg.sv */
// Purpose: shared constants and types of the clock loss supervisor
// Assumes: 20 MHz system clock, oscillator levels sampled synchronously
// Notes:   register offsets are byte addresses on AXI4-Lite
package cls_pkg;
   // clock and derived timing
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned LOSS_TIME_NS  = 5000;
   localparam int unsigned LOSS_CYCLES   = (LOSS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SPIKE_TIME_NS = 100;
   localparam int unsigned SPIKE_CYCLES  = (SPIKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RECOVER_EDGES = 4;

   // register map
   localparam int unsigned ADDR_W      = 4;
   localparam logic [3:0]  ADDR_CTRL   = 4'h0;
   localparam logic [3:0]  ADDR_STATUS = 4'h4;
   localparam logic [3:0]  ADDR_IRQ_EN = 4'h8;

   // field positions and reset values
   localparam int unsigned CTRL_PLL_BIT       = 0;
   localparam int unsigned STAT_ON_BACKUP_BIT = 2;
   localparam logic        CTRL_PLL_RST       = 1'h0;

   // vectors
   localparam logic [3:0]  VEC_CLK_LOSS_NUM  = 4'h1;
   localparam logic [15:0] VEC_CLK_LOSS_ADDR = 16'hfff8;
   localparam logic [3:0]  VEC_AUX_NUM       = 4'hb;
   localparam logic [15:0] VEC_AUX_ADDR      = 16'hffe4;
   localparam logic [3:0]  VEC_NONE_NUM      = 4'h0;
   localparam logic [15:0] VEC_NONE_ADDR     = 16'h0000;

   // bus responses
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // event bits, shared layout of flags and enables
   typedef struct packed {
      logic aux;
      logic loss;
   } cls_evt_t;
   localparam cls_evt_t EVT_RST = '{aux: 1'b0, loss: 1'b0};

   // clock source switch states
   typedef enum logic [3:0] {
      ST_MAIN      = 4'b0001,
      ST_GAP_TO_BK = 4'b0010,
      ST_BACKUP    = 4'b0100,
      ST_GAP_TO_MN = 4'b1000
   } cls_state_t;
endpackage

/* File: design/cls_filters.sv */
// Purpose: spike filter and activity watch for the main oscillator level
// Assumes: raw levels are synchronous to aclk
// Notes:   both hold their state while run is low, except that the watch clears edge_ff
`timescale 1ns/1ps
module cls_spike_filter
   import cls_pkg::*;
#(
   parameter int unsigned MIN_CYC = SPIKE_CYCLES
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic run,
   input  wire logic enable,
   input  wire logic raw,
   output logic      clean_ff
);
   localparam int unsigned CW = $clog2(MIN_CYC + 1);
   logic [CW-1:0] cnt_ff;

   // a new level is accepted only after MIN_CYC agreeing samples
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clean_ff <= 1'b0;
         cnt_ff   <= '0;
      end else if (run) begin
         if (!enable) begin
            clean_ff <= raw;
            cnt_ff   <= '0;
         end else if (raw == clean_ff) begin
            cnt_ff   <= '0;
         end else if (cnt_ff == CW'(MIN_CYC - 1)) begin
            clean_ff <= raw;
            cnt_ff   <= '0;
         end else begin
            cnt_ff   <= cnt_ff + 1'b1;
         end
      end
   end
endmodule // cls_spike_filter

module cls_activity_watch
   import cls_pkg::*;
#(
   parameter int unsigned LIMIT = LOSS_CYCLES
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic run,
   input  wire logic level,
   output logic      edge_ff,
   output logic      stale_ff
);
   localparam int unsigned CW = $clog2(LIMIT + 1);
   logic [CW-1:0] cnt_ff;
   logic          prev_ff;

   // stale after LIMIT cycles without any level change
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_ff  <= 1'b0;
         cnt_ff   <= '0;
         edge_ff  <= 1'b0;
         stale_ff <= 1'b0;
      end else if (run) begin
         prev_ff <= level;
         edge_ff <= (level != prev_ff);
         if (level != prev_ff) begin
            cnt_ff   <= '0;
            stale_ff <= 1'b0;
         end else if (cnt_ff == CW'(LIMIT - 1)) begin
            stale_ff <= 1'b1;
            cnt_ff   <= CW'(LIMIT);
         end else if (!stale_ff) begin
            cnt_ff   <= cnt_ff + 1'b1;
         end
      end else begin
         edge_ff <= 1'b0;
      end
   end
endmodule // cls_activity_watch

/* File: design/cls_supervisor.sv */
// Purpose: clock loss supervisor with backup clock switch and AXI4-Lite registers
// Assumes: main_osc_clock and backup_osc_clock are sampled levels, slower than aclk
// Notes:   cpu_clk_ff is a sampled reconstruction; halt stops it low
`timescale 1ns/1ps
module cls_supervisor
   import cls_pkg::*;
#(
   parameter int unsigned LOSS_CYC  = LOSS_CYCLES,
   parameter int unsigned SPIKE_CYC = SPIKE_CYCLES,
   parameter int unsigned RECOVER_N = RECOVER_EDGES
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // oscillators and clock output
   input  wire logic              main_osc_clock,
   input  wire logic              backup_osc_clock,
   output logic                   backup_osc_en_ff,
   output logic                   cpu_clk_ff,
   output logic                   on_backup_ff,
   // events, modes and interrupt side
   input  wire logic              aux_voltage_event,
   input  wire logic              time_base_irq,
   input  wire logic              cpu_irq_mask,
   input  wire logic              wait_mode,
   input  wire logic              halt_mode,
   output logic                   irq_ff,
   output logic [3:0]             irq_vec_num_ff,
   output logic [15:0]            irq_vec_addr_ff,
   output logic                   wake_wait_ff,
   output logic                   wake_halt_ff,
   // AXI4-Lite slave
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);
   localparam int unsigned RW = $clog2(RECOVER_N + 1);

   logic              run;
   logic              main_clean;
   logic              main_edge;
   logic              main_stale;
   logic              pll_en_ff;
   cls_evt_t          irq_en_ff;
   cls_evt_t          flags_ff;
   cls_evt_t          pend;
   cls_state_t        st_ff;
   logic              req_backup_ff;
   logic [RW-1:0]     good_cnt_ff;
   logic              aw_held_ff;
   logic              w_held_ff;
   logic [ADDR_W-1:0] awaddr_ff;
   logic [31:0]       wdata_ff;
   logic [3:0]        wstrb_ff;
   logic              do_write;
   logic              wr_ctrl;
   logic              wr_stat;
   logic              wr_en;
   logic              any_irq;

   // filter, watch, switch, flags and backup oscillator sleep in halt; interrupt and bus logic keep running
   assign run = !halt_mode;

   cls_spike_filter #(
      .MIN_CYC (SPIKE_CYC)
   ) u_filter (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .run      (run),
      .enable   (pll_en_ff),
      .raw      (main_osc_clock),
      .clean_ff (main_clean)
   );

   cls_activity_watch #(
      .LIMIT (LOSS_CYC)
   ) u_watch (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .run      (run),
      .level    (main_clean),
      .edge_ff  (main_edge),
      .stale_ff (main_stale)
   );

   // write decode; a write in halt is answered but stores nothing
   assign do_write = aw_held_ff && w_held_ff && !s_axi_bvalid;
   assign wr_ctrl  = do_write && run && wstrb_ff[0] && (awaddr_ff == ADDR_CTRL);
   assign wr_stat  = do_write && run && wstrb_ff[0] && (awaddr_ff == ADDR_STATUS);
   assign wr_en    = do_write && run && wstrb_ff[0] && (awaddr_ff == ADDR_IRQ_EN);

   // loss request: set by a dead clock, cleared after enough clean edges
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         req_backup_ff <= 1'b0;
         good_cnt_ff   <= '0;
      end else if (run) begin
         if (main_stale) begin
            req_backup_ff <= 1'b1;
            good_cnt_ff   <= '0;
         end else if (req_backup_ff && main_edge) begin
            if (good_cnt_ff == RW'(RECOVER_N - 1)) begin
               req_backup_ff <= 1'b0;
               good_cnt_ff   <= '0;
            end else begin
               good_cnt_ff   <= good_cnt_ff + 1'b1;
            end
         end
      end
   end

   // source switch: leave a source only at its low phase, enter the next at its low
   // phase, so the gap only stretches a low phase; a dead main may stick high
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff      <= ST_MAIN;
         cpu_clk_ff <= 1'b0;
      end else if (!run) begin
         cpu_clk_ff <= 1'b0;
      end else begin
         case (st_ff)
            ST_MAIN: begin
               if (req_backup_ff && (!main_clean || main_stale)) begin
                  st_ff      <= ST_GAP_TO_BK;
                  cpu_clk_ff <= 1'b0;
               end else begin
                  cpu_clk_ff <= main_clean;
               end
            end
            ST_GAP_TO_BK: begin
               cpu_clk_ff <= 1'b0;
               if (!backup_osc_clock) begin
                  st_ff <= ST_BACKUP;
               end
            end
            ST_BACKUP: begin
               if (!req_backup_ff && !backup_osc_clock) begin
                  st_ff      <= ST_GAP_TO_MN;
                  cpu_clk_ff <= 1'b0;
               end else begin
                  cpu_clk_ff <= backup_osc_clock;
               end
            end
            ST_GAP_TO_MN: begin
               cpu_clk_ff <= 1'b0;
               if (req_backup_ff) begin
                  st_ff <= ST_GAP_TO_BK;
               end else if (!main_clean) begin
                  st_ff <= ST_MAIN;
               end
            end
            default: begin
               st_ff      <= ST_MAIN;
               cpu_clk_ff <= 1'b0;
            end
         endcase
      end
   end

   // backup oscillator runs except in halt; status mirror of the switch
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         backup_osc_en_ff <= 1'b0;
         on_backup_ff     <= 1'b0;
      end else begin
         backup_osc_en_ff <= run;
         on_backup_ff     <= (st_ff == ST_BACKUP);
      end
   end

   // sticky flags, write one to clear; a same-cycle event wins over the clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags_ff <= EVT_RST;
      end else if (run) begin
         flags_ff.loss <= (flags_ff.loss && !(wr_stat && wdata_ff[0]))
                          || (st_ff == ST_BACKUP);
         flags_ff.aux  <= (flags_ff.aux && !(wr_stat && wdata_ff[1]))
                          || aux_voltage_event;
      end
   end

   // configuration, held through halt and restored by reset only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pll_en_ff <= CTRL_PLL_RST;
         irq_en_ff <= EVT_RST;
      end else begin
         if (wr_ctrl) begin
            pll_en_ff <= wdata_ff[CTRL_PLL_BIT];
         end
         if (wr_en) begin
            irq_en_ff <= cls_evt_t'(wdata_ff[1:0]);
         end
      end
   end

   // interrupt request, vector selection and wake signals
   assign pend    = flags_ff & irq_en_ff;
   assign any_irq = (pend.loss || pend.aux) && !cpu_irq_mask;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_ff          <= 1'b0;
         irq_vec_num_ff  <= VEC_NONE_NUM;
         irq_vec_addr_ff <= VEC_NONE_ADDR;
         wake_wait_ff    <= 1'b0;
         wake_halt_ff    <= 1'b0;
      end else begin
         irq_ff       <= any_irq;
         wake_wait_ff <= wait_mode && any_irq;
         // only the time base half of the shared vector may end halt
         wake_halt_ff <= halt_mode && time_base_irq && !cpu_irq_mask;
         if (!cpu_irq_mask && (pend.loss || time_base_irq)) begin
            irq_vec_num_ff  <= VEC_CLK_LOSS_NUM;
            irq_vec_addr_ff <= VEC_CLK_LOSS_ADDR;
         end else if (any_irq) begin
            irq_vec_num_ff  <= VEC_AUX_NUM;
            irq_vec_addr_ff <= VEC_AUX_ADDR;
         end else begin
            irq_vec_num_ff  <= VEC_NONE_NUM;
            irq_vec_addr_ff <= VEC_NONE_ADDR;
         end
      end
   end

   // write channels: address and data taken independently, answered once both held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         aw_held_ff    <= 1'b0;
         w_held_ff     <= 1'b0;
         awaddr_ff     <= '0;
         wdata_ff      <= '0;
         wstrb_ff      <= '0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_ff    <= 1'b1;
            awaddr_ff     <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end else if (!aw_held_ff) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_ff    <= 1'b1;
            wdata_ff     <= s_axi_wdata;
            wstrb_ff     <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end else if (!w_held_ff) begin
            s_axi_wready <= 1'b1;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_ff == ADDR_CTRL || awaddr_ff == ADDR_STATUS
                             || awaddr_ff == ADDR_IRQ_EN) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_held_ff   <= 1'b0;
            w_held_ff    <= 1'b0;
         end
      end
   end

   // read channel: data registered at the edge that takes the address, valid from the next cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= RESP_OKAY;
         case (s_axi_araddr)
            ADDR_CTRL:   s_axi_rdata <= {31'h0, pll_en_ff};
            ADDR_STATUS: s_axi_rdata <= {29'h0, st_ff == ST_BACKUP, flags_ff};
            ADDR_IRQ_EN: s_axi_rdata <= {30'h0, irq_en_ff};
            default: begin
               s_axi_rdata <= '0;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // raw agrees, differs for one sample, then returns to its old level
   sequence s_spike;
      pll_en_ff && run && (main_osc_clock == main_clean)
      ##1 pll_en_ff && run && (main_osc_clock != main_clean)
      ##1 pll_en_ff && run && (main_osc_clock == $past(main_osc_clock, 2));
   endsequence

   a_spike_blocked: assert property (
      s_spike |=> main_clean == $past(main_clean, 3))
      else $error("one-cycle spike reached the filtered main clock");

   a_filter_bypass: assert property (
      !pll_en_ff && run |=> main_clean == $past(main_osc_clock))
      else $error("filter active with pll disabled");

   a_loss_leave: assert property (
      st_ff == ST_MAIN && req_backup_ff && main_stale && run |=> st_ff == ST_GAP_TO_BK)
      else $error("dead main clock not left");

   a_auto_return: assert property (
      st_ff == ST_BACKUP && !req_backup_ff && !backup_osc_clock && run
      |=> st_ff == ST_GAP_TO_MN)
      else $error("no return toward main clock");

   a_flag_backup: assert property (
      st_ff == ST_BACKUP && run |=> flags_ff.loss)
      else $error("loss flag clear while on backup");

   a_irq_gate: assert property (
      (cpu_irq_mask |=> !irq_ff) and (pend.loss && !cpu_irq_mask |=> irq_ff))
      else $error("interrupt gating wrong");

   a_wait_wake: assert property (
      wait_mode && any_irq |=> wake_wait_ff && irq_ff)
      else $error("no wake from wait");

   a_halt_freeze: assert property (
      halt_mode |=> $stable(flags_ff) && $stable(st_ff) && !backup_osc_en_ff && !cpu_clk_ff)
      else $error("supervisor active in halt");

   a_halt_nowake: assert property (
      !time_base_irq |=> !wake_halt_ff)
      else $error("halt wake without time base interrupt");

   a_vector_map: assert property (
      (irq_vec_num_ff == VEC_CLK_LOSS_NUM |-> irq_vec_addr_ff == VEC_CLK_LOSS_ADDR)
      and (irq_vec_num_ff == VEC_AUX_NUM |-> irq_vec_addr_ff == VEC_AUX_ADDR))
      else $error("vector number and address disagree");

   a_no_runt: assert property (
      $changed(st_ff) |-> !cpu_clk_ff)
      else $error("clock high across a source change");
endmodule // cls_supervisor

/* File: sim/tb_clock_loss_supervisor.sv */
// Purpose: self-checking bench for the clock loss supervisor
// Assumes: short loss and recovery counts so a run stays brief
// Notes:   oscillator levels are made here; the backup only runs while enabled
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
   $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end
module tb_clock_loss_supervisor
   import cls_pkg::*;
;
   typedef struct {logic wr; logic [3:0] a; logic [31:0] d; logic [1:0] resp;} cls_row_t;
   logic aclk = 0, aresetn = 0, main_osc_clock = 0, backup_osc_clock = 0;
   logic aux_voltage_event = 0, time_base_irq = 0, cpu_irq_mask = 0;
   logic wait_mode = 0, halt_mode = 0;
   logic backup_osc_en_ff, cpu_clk_ff, on_backup_ff, irq_ff, wake_wait_ff, wake_halt_ff;
   logic [3:0]  irq_vec_num_ff;
   logic [15:0] irq_vec_addr_ff;
   logic [3:0]  s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic        main_run = 1, spike_on = 0, watch_clk = 0, last_clk = 0, prev_cpu = 0;
   int          fail_count = 0, n_compared = 0, cyc = 0, run_len = 0, ph = 0, n;
   cls_row_t    rows [10] = '{
      '{0, 4'h0, 32'h0, 2'h0}, '{0, 4'h4, 32'h0, 2'h0}, '{0, 4'h8, 32'h0, 2'h0},
      '{1, 4'h0, 32'h1, 2'h0}, '{0, 4'h0, 32'h1, 2'h0}, '{1, 4'h8, 32'h3, 2'h0},
      '{0, 4'h8, 32'h3, 2'h0}, '{0, 4'hc, 32'h0, 2'h2}, '{1, 4'hc, 32'h1, 2'h2},
      '{0, 4'h4, 32'h0, 2'h0}};

   cls_supervisor #(.LOSS_CYC(10), .SPIKE_CYC(2), .RECOVER_N(2)) dut_u (
      .aclk, .aresetn, .main_osc_clock, .backup_osc_clock, .backup_osc_en_ff,
      .cpu_clk_ff, .on_backup_ff, .aux_voltage_event, .time_base_irq, .cpu_irq_mask,
      .wait_mode, .halt_mode, .irq_ff, .irq_vec_num_ff, .irq_vec_addr_ff,
      .wake_wait_ff, .wake_halt_ff, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

   initial begin
      forever #25 aclk = ~aclk;
   end

   // main toggles every 3 cycles; when stopped it sits low with optional 1-cycle spikes
   always @(posedge aclk) begin
      ph <= ph + 1;
      if (main_run) begin
         if (ph % 3 == 0) main_osc_clock <= ~main_osc_clock;
      end else begin
         main_osc_clock <= spike_on && (ph % 5 == 0);
      end
      backup_osc_clock <= backup_osc_en_ff === 1'b1 && (ph % 2 == 0) ? ~backup_osc_clock
                          : (backup_osc_en_ff === 1'b1 ? backup_osc_clock : 1'b0);
   end

   // a truncated cpu clock phase would last a single cycle, both sources give longer ones
   always @(posedge aclk) begin
      if (cpu_clk_ff !== last_clk) begin
         if (watch_clk) `CHK(run_len >= 2, 1'b1)
         run_len = 1;
      end else begin
         run_len = run_len + 1;
      end
      last_clk = cpu_clk_ff;
   end

   // hang guard, well above the few hundred cycles the sequence needs
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 8000) begin
         fail_count++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge aclk);
   endtask

   // address and data offered together, each dropped once taken
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      int k;
      k = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         k++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && k < 100);
      if (s_axi_bvalid !== 1'b1) begin
         fail_count++;
         $display("[FAIL] %0t write response timed out", $time);
      end
      r = s_axi_bresp;
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      s_axi_bready <= 1'b0;
      // let an edge pass so a following call never re-drives in this time step
      @(posedge aclk);
   endtask

   task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      int k;
      k = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         k++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && k < 100);
      if (s_axi_rvalid !== 1'b1) begin
         fail_count++;
         $display("[FAIL] %0t read data timed out", $time);
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask

   initial begin
      tick(20);
      aresetn <= 1'b1;
      tick(2);
      // register table: reset values, access kinds, unmapped place
      foreach (rows[i]) begin
         if (rows[i].wr) begin
            axi_wr(rows[i].a, rows[i].d, rsp);
         end else begin
            axi_rd(rows[i].a, rd, rsp);
            `CHK(rd, rows[i].d)
         end
         `CHK(rsp, rows[i].resp)
      end
      // main lost while spikes arrive; with the filter on they must not count as clock
      watch_clk = 1;
      main_run <= 1'b0;
      spike_on <= 1'b1;
      for (n = 0; n < 80 && on_backup_ff !== 1'b1; n++) tick(1);
      `CHK(on_backup_ff, 1'b1)
      tick(3);
      `CHK({irq_ff, irq_vec_num_ff, irq_vec_addr_ff}, {1'b1, 4'h1, 16'hfff8})
      axi_rd(ADDR_STATUS, rd, rsp);
      `CHK(rd, 32'h5)
      // own history: last_clk is rewritten by another process at the same edge
      n = 0;
      prev_cpu = cpu_clk_ff;
      repeat (20) begin
         @(posedge aclk);
         if (cpu_clk_ff === 1'b1 && prev_cpu === 1'b0) n++;
         prev_cpu = cpu_clk_ff;
      end
      `CHK(n > 0, 1'b1)
      cpu_irq_mask <= 1'b1;
      tick(3);
      `CHK(irq_ff, 1'b0)
      cpu_irq_mask <= 1'b0;
      wait_mode <= 1'b1;
      tick(3);
      `CHK({irq_ff, wake_wait_ff}, 2'b11)
      wait_mode <= 1'b0;
      // main returns: switch back with no software help
      spike_on <= 1'b0;
      main_run <= 1'b1;
      for (n = 0; n < 150 && on_backup_ff !== 1'b0; n++) tick(1);
      `CHK(on_backup_ff, 1'b0)
      tick(6);
      axi_wr(ADDR_STATUS, 32'h1, rsp);
      axi_rd(ADDR_STATUS, rd, rsp);
      `CHK(rd, 32'h0)
      watch_clk = 0;
      // aux event has its own flag, enable and vector
      aux_voltage_event <= 1'b1;
      tick(1);
      aux_voltage_event <= 1'b0;
      tick(3);
      `CHK({irq_ff, irq_vec_num_ff, irq_vec_addr_ff}, {1'b1, 4'hb, 16'hffe4})
      axi_wr(ADDR_IRQ_EN, 32'h1, rsp);
      tick(3);
      `CHK(irq_ff, 1'b0)
      axi_wr(ADDR_STATUS, 32'h2, rsp);
      axi_wr(ADDR_IRQ_EN, 32'h3, rsp);
      // halt: frozen registers, supervisor off, only the time base wakes
      halt_mode <= 1'b1;
      tick(2);
      aux_voltage_event <= 1'b1;
      tick(1);
      aux_voltage_event <= 1'b0;
      axi_wr(ADDR_CTRL, 32'h0, rsp);
      tick(2);
      `CHK({backup_osc_en_ff, cpu_clk_ff, wake_halt_ff}, 3'b000)
      time_base_irq <= 1'b1;
      tick(3);
      `CHK(wake_halt_ff, 1'b1)
      time_base_irq <= 1'b0;
      halt_mode <= 1'b0;
      tick(2);
      axi_rd(ADDR_CTRL, rd, rsp);
      `CHK(rd, 32'h1)
      axi_rd(ADDR_STATUS, rd, rsp);
      `CHK(rd, 32'h0)
      // a reset in mid-run brings the configuration back to its reset values
      aresetn <= 1'b0;
      tick(2);
      aresetn <= 1'b1;
      tick(2);
      axi_rd(ADDR_CTRL, rd, rsp);
      `CHK(rd, 32'h0)
      finish_test();
   end
endmodule // tb_clock_loss_supervisor
